// >>> hw/audio_clock_pkg.sv
package audio_clock_pkg;

  // ----------------------------------------------------------------
  // Bus widths and answers
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 12;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ----------------------------------------------------------------
  // Register indexes, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_CPF_LOW     = 8'h30;
  localparam logic [7:0]  IDX_CPF_MID     = 8'h31;
  localparam logic [7:0]  IDX_CPF_HIGH    = 8'h32;
  localparam logic [7:0]  IDX_NI_LOW      = 8'h34;
  localparam logic [7:0]  IDX_NI_MID      = 8'h35;
  localparam logic [7:0]  IDX_NI_HIGH     = 8'h36;
  localparam logic [7:0]  IDX_BIT_DIV     = 8'h38;
  localparam logic [7:0]  IDX_CH_DIV      = 8'h39;
  localparam logic [7:0]  IDX_CONTROL     = 8'h3A;
  localparam logic [7:0]  IDX_FIELD_COUNT = 8'h3C;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int CTRL_PLL_OPEN_BIT  = 3;
  localparam int CTRL_VREF_BIT      = 2;
  localparam int CTRL_CH_PHASE_BIT  = 1;
  localparam int CTRL_BIT_PHASE_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values and loop constants
  // ----------------------------------------------------------------
  localparam logic [17:0] CPF_RESET  = 18'h00000;
  localparam logic [21:0] NI_RESET   = 22'h000000;
  localparam logic [5:0]  DIV_RESET  = 6'h00;
  localparam logic [3:0]  CTRL_RESET = 4'h0;
  localparam int          ACC_W      = 23;
  localparam int          LOOP_SHIFT = 8;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] bit_div;
    logic [5:0] ch_div;
    logic       bit_phase;
    logic       ch_phase;
  } edge_cfg_t;

  typedef struct packed {
    logic [17:0] cpf;
    logic [21:0] ni;
    logic [5:0]  bit_div;
    logic [5:0]  ch_div;
    logic [3:0]  ctrl;
  } audio_regs_t;

endpackage

// >>> hw/field_locked_audio_clock_divider.sv
// Function
// - Bit clock equals source over 2(divisor+1).
// - Channel clock equals bit clock over 2divisor.
// - Both outputs made by binary division.
// - PLL bit zero closed, one open.
// - Vertical reference select: internal or external.
// - Channel phase zero: change on falling edges.
// - Channel phase one: change on rising edges.
// - Bit phase picks source falling or rising.
// - Divider input only from source clock pin.
// - Master clock rate from per-field and increment.
// - Slow loop locks audio clock to fields.
// - Same master clock count every field.
//
// Chosen here: register access over AXI4-Lite.
module field_locked_audio_clock_divider
  import audio_clock_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  // AXI4-Lite write response
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  output      logic [31:0]       s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Pins and vertical references
  input  wire logic              divider_source_clock_in,
  input  wire logic              vertical_ref_internal_in,
  input  wire logic              vertical_ref_external_in,
  // Audio clock outputs
  output      logic              synth_master_clock_out,
  output      logic              serial_bit_clock_out,
  output      logic              channel_select_clock_out
);

  // ----------------------------------------------------------------
  // Register map and bus slave
  // ----------------------------------------------------------------
  audio_regs_t             regs, next_regs;
  logic                    aw_held, next_aw_held;
  logic [ADDR_W-1:0]       aw_addr, next_aw_addr;
  logic                    w_held, next_w_held;
  logic [7:0]              w_byte, next_w_byte;
  logic                    w_lane, next_w_lane;
  logic                    next_awready, next_wready, next_arready;
  logic [1:0]              next_bresp, next_rresp;
  logic                    next_bvalid, next_rvalid;
  logic [31:0]             next_rdata;
  logic [17:0]             field_count;

  // Returns the register index, or all ones when the address is unmapped.
  function automatic logic [8:0] decode(input logic [ADDR_W-1:0] addr);
    logic [7:0] idx;
    logic       hit;
    idx = addr[9:2];
    hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:10] == '0);
    if (hit && (idx == IDX_CPF_LOW || idx == IDX_CPF_MID || idx == IDX_CPF_HIGH ||
                idx == IDX_NI_LOW || idx == IDX_NI_MID || idx == IDX_NI_HIGH ||
                idx == IDX_BIT_DIV || idx == IDX_CH_DIV || idx == IDX_CONTROL ||
                idx == IDX_FIELD_COUNT)) begin
      return {1'b0, idx};
    end
    return 9'h1FF;
  endfunction

  always_comb begin
    logic [8:0] widx;
    logic [8:0] ridx;
    next_regs    = regs;
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_byte  = w_byte;
    next_w_lane  = w_lane;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rresp   = s_axi_rresp;
    next_rdata   = s_axi_rdata;
    widx         = decode(aw_addr);
    ridx         = decode(s_axi_araddr);
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    // Only byte lane zero carries a register byte; the other lanes are ignored.
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_byte = s_axi_wdata[7:0];
      next_w_lane = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !s_axi_bvalid) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (widx == 9'h1FF) ? RESP_SLVERR : RESP_OKAY;
      if (w_lane) begin
        unique case (widx[7:0])
          IDX_CPF_LOW:  next_regs.cpf[7:0]   = w_byte;
          IDX_CPF_MID:  next_regs.cpf[15:8]  = w_byte;
          IDX_CPF_HIGH: next_regs.cpf[17:16] = w_byte[1:0];
          IDX_NI_LOW:   next_regs.ni[7:0]    = w_byte;
          IDX_NI_MID:   next_regs.ni[15:8]   = w_byte;
          IDX_NI_HIGH:  next_regs.ni[21:16]  = w_byte[5:0];
          IDX_BIT_DIV:  next_regs.bit_div    = w_byte[5:0];
          IDX_CH_DIV:   next_regs.ch_div     = w_byte[5:0];
          IDX_CONTROL:  next_regs.ctrl       = w_byte[3:0];
          // The measured field count is read-only, so a write to it is dropped.
          default:      next_regs            = regs;
        endcase
      end
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = (ridx == 9'h1FF) ? RESP_SLVERR : RESP_OKAY;
      unique case (ridx[7:0])
        IDX_CPF_LOW:     next_rdata = {24'h000000, regs.cpf[7:0]};
        IDX_CPF_MID:     next_rdata = {24'h000000, regs.cpf[15:8]};
        IDX_CPF_HIGH:    next_rdata = {30'h00000000, regs.cpf[17:16]};
        IDX_NI_LOW:      next_rdata = {24'h000000, regs.ni[7:0]};
        IDX_NI_MID:      next_rdata = {24'h000000, regs.ni[15:8]};
        IDX_NI_HIGH:     next_rdata = {26'h0000000, regs.ni[21:16]};
        IDX_BIT_DIV:     next_rdata = {26'h0000000, regs.bit_div};
        IDX_CH_DIV:      next_rdata = {26'h0000000, regs.ch_div};
        IDX_CONTROL:     next_rdata = {28'h0000000, regs.ctrl};
        IDX_FIELD_COUNT: next_rdata = {14'h0000, field_count};
        default:         next_rdata = 32'h00000000;
      endcase
    end
    // Ready is registered, so a held channel stays closed until the answer is gone.
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      regs          <= '{cpf: CPF_RESET, ni: NI_RESET, bit_div: DIV_RESET, ch_div: DIV_RESET, ctrl: CTRL_RESET};
      aw_held       <= 1'b0;
      aw_addr       <= '0;
      w_held        <= 1'b0;
      w_byte        <= 8'h00;
      w_lane        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
    end else begin
      regs          <= next_regs;
      aw_held       <= next_aw_held;
      aw_addr       <= next_aw_addr;
      w_held        <= next_w_held;
      w_byte        <= next_w_byte;
      w_lane        <= next_w_lane;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_arready <= next_arready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rresp   <= next_rresp;
      s_axi_rdata   <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Bit clock and channel clock dividers
  // ----------------------------------------------------------------
  // The source pin is sampled, so it must stay below a quarter of aclk.
  logic       src_meta, src_sync, src_prev;
  edge_cfg_t  active, next_active;
  logic [5:0] bit_cnt, next_bit_cnt;
  logic [5:0] ch_cnt, next_ch_cnt;
  logic       next_bit_clk, next_ch_clk;

  always_comb begin
    logic src_edge;
    logic bit_edge;
    next_active  = active;
    next_bit_cnt = bit_cnt;
    next_ch_cnt  = ch_cnt;
    next_bit_clk = serial_bit_clock_out;
    next_ch_clk  = channel_select_clock_out;
    bit_edge     = 1'b0;
    src_edge     = active.bit_phase ? (src_sync && !src_prev) : (!src_sync && src_prev);
    if (src_edge) begin
      if (bit_cnt >= active.bit_div) begin
        next_bit_clk           = !serial_bit_clock_out;
        next_bit_cnt           = 6'h00;
        next_active.bit_div    = regs.bit_div;
        next_active.bit_phase  = regs.ctrl[CTRL_BIT_PHASE_BIT];
        // Channel edge is a rising bit clock edge for phase one, falling for phase zero.
        bit_edge = (next_bit_clk == active.ch_phase);
      end else begin
        next_bit_cnt = bit_cnt + 6'h01;
      end
    end
    if (bit_edge) begin
      // A divisor of zero holds the channel clock still and keeps reloading.
      if (active.ch_div == 6'h00) begin
        next_ch_cnt          = 6'h00;
        next_active.ch_div   = regs.ch_div;
        next_active.ch_phase = regs.ctrl[CTRL_CH_PHASE_BIT];
      end else if (ch_cnt >= active.ch_div - 6'h01) begin
        next_ch_clk          = !channel_select_clock_out;
        next_ch_cnt          = 6'h00;
        next_active.ch_div   = regs.ch_div;
        next_active.ch_phase = regs.ctrl[CTRL_CH_PHASE_BIT];
      end else begin
        next_ch_cnt = ch_cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_meta                 <= 1'b0;
      src_sync                 <= 1'b0;
      src_prev                 <= 1'b0;
      active                   <= '{bit_div: DIV_RESET, ch_div: DIV_RESET, bit_phase: 1'b0, ch_phase: 1'b0};
      bit_cnt                  <= 6'h00;
      ch_cnt                   <= 6'h00;
      serial_bit_clock_out     <= 1'b0;
      channel_select_clock_out <= 1'b0;
    end else begin
      src_meta                 <= divider_source_clock_in;
      src_sync                 <= src_meta;
      src_prev                 <= src_sync;
      active                   <= next_active;
      bit_cnt                  <= next_bit_cnt;
      ch_cnt                   <= next_ch_cnt;
      serial_bit_clock_out     <= next_bit_clk;
      channel_select_clock_out <= next_ch_clk;
    end
  end

  // ----------------------------------------------------------------
  // Master clock synthesizer and field lock loop
  // ----------------------------------------------------------------
  // The aclk stands in for the crystal; the loop is slow so one bad field barely moves it.
  // A count error moves the increment by only its value over 256 per field, so lock takes long.
  logic [ACC_W-1:0]  acc, next_acc;
  logic              next_mclk;
  logic              vref_meta, vref_sync, vref_prev, next_vref_prev;
  logic [17:0]       clk_count, next_clk_count;
  logic [17:0]       next_field_count;
  logic signed [24:0] offset, next_offset;

  always_comb begin
    logic signed [24:0] inc_wide;
    logic [ACC_W-1:0]   inc;
    logic               vref_sel;
    logic               mclk_rise;
    logic [25:0]        sum_wide;
    inc       = '0;
    vref_sel  = 1'b0;
    mclk_rise = 1'b0;
    sum_wide  = '0;
    inc_wide = $signed({3'h0, regs.ni}) + (offset >>> LOOP_SHIFT);
    if (inc_wide < 0) begin
      inc = '0;
    end else if (inc_wide > 25'sh07FFFFF) begin
      inc = '1;
    end else begin
      inc = inc_wide[ACC_W-1:0];
    end
    next_acc         = acc + inc;
    next_mclk        = next_acc[ACC_W-1];
    mclk_rise        = next_mclk && !synth_master_clock_out;
    vref_sel         = regs.ctrl[CTRL_VREF_BIT] ? vref_sync : vertical_ref_internal_in;
    next_vref_prev   = vref_sel;
    next_clk_count   = mclk_rise ? clk_count + 18'h00001 : clk_count;
    next_field_count = field_count;
    next_offset      = offset;
    if (vref_sel && !vref_prev) begin
      next_field_count = clk_count;
      next_clk_count   = mclk_rise ? 18'h00001 : 18'h00000;
      // Drive the count per field toward the programmed value.
      // The error sum saturates, so a long run far off target cannot flip its sign.
      sum_wide = {offset[24], offset} + {8'h00, regs.cpf} - {8'h00, clk_count};
      if (sum_wide[25] != sum_wide[24]) begin
        next_offset = sum_wide[25] ? 25'sh1000000 : 25'sh0FFFFFF;
      end else begin
        next_offset = $signed(sum_wide[24:0]);
      end
    end
    if (regs.ctrl[CTRL_PLL_OPEN_BIT]) begin
      next_offset = 25'sh0000000;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc                    <= '0;
      synth_master_clock_out <= 1'b0;
      vref_meta              <= 1'b0;
      vref_sync              <= 1'b0;
      vref_prev              <= 1'b0;
      clk_count              <= 18'h00000;
      field_count            <= 18'h00000;
      offset                 <= 25'sh0000000;
    end else begin
      acc                    <= next_acc;
      synth_master_clock_out <= next_mclk;
      vref_meta              <= vertical_ref_external_in;
      vref_sync              <= vref_meta;
      vref_prev              <= next_vref_prev;
      clk_count              <= next_clk_count;
      field_count            <= next_field_count;
      offset                 <= next_offset;
    end
  end

endmodule

// >>> sim/audio_clock_monitor.sv
module audio_clock_monitor
  import audio_clock_pkg::*;
(
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Register bus
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // Audio clocks
  input wire logic              serial_bit_clock_out,
  input wire logic              channel_select_clock_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reset_quiet_a: assert property ($rose(aresetn) |-> !s_axi_awready && !s_axi_arready && !s_axi_bvalid)
    else $error("bus active at reset release");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h0CC
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  channel_edge_a: assert property ($changed(channel_select_clock_out) |-> $changed(serial_bit_clock_out))
    else $error("channel clock moved without a bit clock edge");
  bit_spacing_a: assert property ($changed(serial_bit_clock_out) |=> !$changed(serial_bit_clock_out) [*2])
    else $error("bit clock edges too close");

  write_seen_c: cover property (s_axi_bvalid && s_axi_bready);
  read_seen_c: cover property (s_axi_rvalid && s_axi_rready);
  channel_seen_c: cover property ($rose(channel_select_clock_out));
endmodule

bind field_locked_audio_clock_divider audio_clock_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_bit_clock_out,
  .channel_select_clock_out);

// >>> sim/audio_source_model.sv
module audio_source_model #(
  parameter int SRC_HALF_NS    = 400,
  parameter int VREF_PERIOD_NS = 40000
) (
  // Clocks towards the divider
  output logic source_clock,
  output logic vertical_ref,
  output int   source_rises
);
  timeunit 1ns;
  timeprecision 1ps;

  // A master oscillator runs free, so the source clock never stands still.
  initial begin
    source_clock = 1'b0;
    #13;
    forever #(SRC_HALF_NS) source_clock = ~source_clock;
  end

  initial begin
    vertical_ref = 1'b0;
    #7;
    forever begin
      #(VREF_PERIOD_NS - 1000) vertical_ref = 1'b1;
      #1000 vertical_ref = 1'b0;
    end
  end

  initial source_rises = 0;
  always @(posedge source_clock) source_rises++;
endmodule

// >>> sim/tb.sv
module tb import audio_clock_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, vertical_ref_internal_in = 1'b0, bit_q = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic divider_source_clock_in, vertical_ref_external_in;
  logic synth_master_clock_out, serial_bit_clock_out, channel_select_clock_out;
  logic [31:0] d;
  int n_mismatch = 0, checked = 0, vcnt = 0, bit_rises = 0, src_rises, s0, b0;
  logic [7:0] idx_t [9] = '{8'h30, 8'h31, 8'h32, 8'h34, 8'h35, 8'h36, 8'h38, 8'h39, 8'h3A};
  logic [7:0] mask_t [9] = '{8'hFF, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'h3F, 8'h3F, 8'h3F, 8'h0F};
  int bd [4] = '{1, 0, 3, 63};
  int cd [4] = '{2, 3, 1, 1};
  int ct [4] = '{3, 0, 2, 1};

  field_locked_audio_clock_divider DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .divider_source_clock_in, .vertical_ref_internal_in, .vertical_ref_external_in, .synth_master_clock_out,
    .serial_bit_clock_out, .channel_select_clock_out);
  audio_source_model u_src (.source_clock(divider_source_clock_in), .vertical_ref(vertical_ref_external_in),
    .source_rises(src_rises));

  initial forever #25 aclk = ~aclk;
  // Internal field reference every 400 cycles, so four-cycle master periods give exact counts.
  always @(posedge aclk) begin
    vcnt <= (vcnt == 399) ? 0 : vcnt + 1;
    vertical_ref_internal_in <= (vcnt < 20);
    bit_q <= serial_bit_clock_out;
    if (serial_bit_clock_out && !bit_q) bit_rises <= bit_rises + 1;
  end

  // ----------------------------------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------------------------------
  function automatic logic [11:0] a(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic give_up();
    n_mismatch++;
    $display("wrong value at %0t: wait ran out", $time);
    summarize();
  endtask
  task automatic wr(input logic [11:0] ad, input logic [7:0] dt, input logic [3:0] st, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, dt};
    s_axi_wstrb <= st;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    if (n == 100) give_up();
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] ad, output logic [31:0] dt, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    if (n == 100) give_up();
    dt = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic expect_reg(input logic [11:0] ad, input logic [31:0] exp, input logic [1:0] exp_r);
    rd(ad, d, resp);
    check(d, exp);
    check(32'(resp), 32'(exp_r));
  endtask
  task automatic set(input logic [7:0] idx, input logic [7:0] dt);
    wr(a(idx), dt, 4'hF, resp);
    check(32'(resp), 32'(RESP_OKAY));
  endtask
  task automatic wait_rise(input int sel);
    int n;
    logic p;
    p = sel ? channel_select_clock_out : serial_bit_clock_out;
    for (n = 0; n < 20000; n++) begin
      @(posedge aclk);
      #1;
      if ((sel ? channel_select_clock_out : serial_bit_clock_out) && !p) break;
      p = sel ? channel_select_clock_out : serial_bit_clock_out;
    end
    if (n == 20000) give_up();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 9; i++) expect_reg(a(idx_t[i]), 32'h0, RESP_OKAY);
    for (int i = 0; i < 9; i++) begin
      set(idx_t[i], 8'hFF);
      expect_reg(a(idx_t[i]), 32'(mask_t[i]), RESP_OKAY);
    end
    wr(a(IDX_BIT_DIV), 8'h00, 4'h0, resp);
    check(32'(resp), 32'(RESP_OKAY));
    expect_reg(a(IDX_BIT_DIV), 32'h3F, RESP_OKAY);
    wr(a(8'h33), 8'h5A, 4'hF, resp);
    check(32'(resp), 32'(RESP_SLVERR));
    expect_reg(a(8'h33), 32'h0, RESP_SLVERR);
    expect_reg(a(IDX_BIT_DIV) + 12'h001, 32'h0, RESP_SLVERR);
    // Settings change only at terminal count, so two channel clock rises pass before measuring.
    for (int i = 0; i < 4; i++) begin
      set(IDX_BIT_DIV, 8'(bd[i]));
      set(IDX_CH_DIV, 8'(cd[i]));
      set(IDX_CONTROL, 8'(ct[i]));
      wait_rise(1);
      wait_rise(1);
      wait_rise(0);
      check(32'(divider_source_clock_in), 32'(ct[i] % 2));
      s0 = src_rises;
      wait_rise(0);
      check(32'(src_rises - s0), 32'(2 * (bd[i] + 1)));
      wait_rise(1);
      check(32'(serial_bit_clock_out), 32'((ct[i] / 2) % 2));
      b0 = bit_rises;
      wait_rise(1);
      check(32'(bit_rises - b0), 32'(2 * cd[i]));
    end
    set(IDX_NI_LOW, 8'h00);
    set(IDX_NI_MID, 8'h00);
    set(IDX_NI_HIGH, 8'h20);
    set(IDX_CONTROL, 8'h08);
    repeat (1200) @(posedge aclk);
    expect_reg(a(IDX_FIELD_COUNT), 32'd100, RESP_OKAY);
    set(IDX_CONTROL, 8'h0C);
    repeat (2000) @(posedge aclk);
    expect_reg(a(IDX_FIELD_COUNT), 32'd200, RESP_OKAY);
    set(IDX_CONTROL, 8'h00);
    repeat (16000) @(posedge aclk);
    rd(a(IDX_FIELD_COUNT), d, resp);
    check(32'(d > 32'd100), 32'h1);
    set(IDX_CONTROL, 8'h08);
    repeat (1200) @(posedge aclk);
    expect_reg(a(IDX_FIELD_COUNT), 32'd100, RESP_OKAY);
    // Five megahertz over a fifty kilohertz field rate is exactly one hundred.
    set(IDX_CPF_LOW, 8'h64);
    set(IDX_CPF_MID, 8'h00);
    set(IDX_CPF_HIGH, 8'h00);
    set(IDX_CONTROL, 8'h00);
    repeat (4000) @(posedge aclk);
    expect_reg(a(IDX_FIELD_COUNT), 32'd100, RESP_OKAY);
    summarize();
  end
endmodule
